// ---- cmd_pkg.sv ----
package cmd_pkg;

  localparam logic [7:0] OP_SPIN_POS      = 8'h01;
  localparam logic [7:0] OP_SPIN_NEG      = 8'h02;
  localparam logic [7:0] OP_SOFT_HALT     = 8'h03;
  localparam logic [7:0] OP_HANDLER_RET   = 8'h26;
  localparam logic [7:0] OP_VAR_ARITH_LO  = 8'h28;
  localparam logic [7:0] OP_VAR_ARITH_HI  = 8'h2D;
  localparam logic [7:0] OP_GOTO_ACCU     = 8'h2E;
  localparam logic [7:0] OP_RESTART       = 8'h30;
  localparam logic [7:0] OP_DEC_BRANCH    = 8'h31;
  localparam logic [7:0] OP_SPIN_NEG_ACCU = 8'h32;
  localparam logic [7:0] OP_SPIN_POS_ACCU = 8'h33;
  localparam logic [7:0] OP_IDX_VAR_LO    = 8'h37;
  localparam logic [7:0] OP_IDX_VAR_HI    = 8'h39;
  localparam logic [7:0] OP_COND_CALL     = 8'h50;

  localparam logic [7:0] PARAM_TARGET_SPEED    = 8'h00;
  localparam logic [7:0] PARAM_TARGET_VELOCITY = 8'h02;

  localparam logic [7:0] STATUS_OK          = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHKSUM  = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD     = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE    = 8'h03;

  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [3:0] IDX_INSTR  = 4'h1;
  localparam logic [3:0] IDX_TYPE   = 4'h2;
  localparam logic [3:0] IDX_MOTOR  = 4'h3;
  localparam logic [3:0] IDX_VAL_LO = 4'h4;
  localparam logic [7:0] MODULE_ADDR_RESET = 8'h01;

  typedef struct packed {
    logic [7:0]  instr;
    logic [7:0]  op_type;
    logic [7:0]  motor;
    logic [31:0] value;
  } cmd_frame_t;

  typedef struct packed {
    logic        valid;
    logic        velocity_mode;
    logic [7:0]  param;
    logic [31:0] value;
  } axis_write_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } reply_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [3:0]  flags;
  } context_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_MODE    = 5'b00010,
    ST_PARAM   = 5'b00100,
    ST_REPLY   = 5'b01000,
    ST_WAIT    = 5'b10000
  } cmd_state_t;

endpackage

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cmd_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            reply_valid,
  input  wire cmd_pkg::reply_t reply,
  output var  logic [7:0]      rx_byte,
  output var  logic            rx_valid,
  output var  logic            reply_ready
);
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    reply_ready = 1'b0;
  end
  // gap idle cycles after each byte models a slow host
  task automatic send(input logic [7:0] ins, mot, input logic [31:0] val,
                      input logic bad, input int gap, output reply_t rsp);
    logic [7:0] b [9];
    int         n;
    b = '{8'h01, ins, 8'h00, mot, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    if (bad) b[8] = ~b[8];
    for (int i = 0; i < 9; i++) begin
      @(negedge mclk);
      rx_byte <= b[i];
      rx_valid <= 1'b1;
      repeat (gap) begin
        @(negedge mclk);
        rx_valid <= 1'b0;
        rx_byte <= ~b[i];
      end
    end
    @(negedge mclk);
    rx_valid <= 1'b0;
    rx_byte <= ~b[8];
    n = 0;
    while (reply_valid !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    rsp = (n < 30) ? reply : 'x;
    reply_ready <= 1'b1;
    @(negedge mclk);
    reply_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- stepper_command_interpreter.sv ----
`timescale 1ns/1ps
`default_nettype none
module stepper_command_interpreter
  import cmd_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [7:0]            rx_byte,
  input  wire logic                  rx_valid,
  input  wire logic                  irq_request,
  input  wire cmd_pkg::context_t     live_context,
  output var  cmd_pkg::axis_write_t  axis_write,
  output var  logic                  spin_dir_negative,
  output var  cmd_pkg::reply_t       reply,
  output var  logic                  reply_valid,
  input  wire logic                  reply_ready,
  output var  logic                  ext_op_valid,
  output var  logic [7:0]            ext_op,
  output var  cmd_pkg::cmd_frame_t   ext_frame,
  output var  logic                  handler_active,
  output var  logic                  handler_enter,
  output var  cmd_pkg::context_t     saved_context,
  output var  logic                  context_restore
);
  import cmd_pkg::*;

  function automatic logic is_motion(input logic [7:0] op);
    is_motion = (op == OP_SPIN_POS) || (op == OP_SPIN_NEG) || (op == OP_SOFT_HALT);
  endfunction

  function automatic logic is_extended(input logic [7:0] op);
    is_extended = (op >= OP_VAR_ARITH_LO && op <= OP_VAR_ARITH_HI) ||
                  (op == OP_GOTO_ACCU) || (op == OP_RESTART) ||
                  (op == OP_DEC_BRANCH) || (op == OP_SPIN_NEG_ACCU) ||
                  (op == OP_SPIN_POS_ACCU) ||
                  (op >= OP_IDX_VAR_LO && op <= OP_IDX_VAR_HI) ||
                  (op == OP_COND_CALL);
  endfunction

  logic [7:0]  frame_buf [0:8];
  logic [3:0]  byte_idx;
  logic [7:0]  chk_sum;
  logic        frame_done;
  cmd_frame_t  frame;
  cmd_state_t  state;
  logic        chk_ok;
  logic        fields_ok;

  // frame capture, mod-256 sum of bytes 0..7
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      byte_idx   <= 4'h0;
      chk_sum    <= 8'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (rx_valid && state == ST_IDLE) begin
        if (byte_idx == FRAME_LAST) begin
          byte_idx   <= 4'h0;
          chk_sum    <= 8'h00;
          frame_done <= 1'b1;
        end else begin
          byte_idx <= byte_idx + 4'h1;
          chk_sum  <= chk_sum + rx_byte;
        end
      end
    end
  end

  // no reset: only a completed frame is ever decoded
  always_ff @(posedge mclk) begin
    if (rx_valid && state == ST_IDLE) begin
      frame_buf[byte_idx] <= rx_byte;
    end
  end

  logic [7:0] chk_final;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chk_final <= 8'h00;
    end else if (rx_valid && state == ST_IDLE && byte_idx == FRAME_LAST) begin
      chk_final <= chk_sum;
    end
  end

  always_comb begin
    frame.instr   = frame_buf[IDX_INSTR];
    frame.op_type = frame_buf[IDX_TYPE];
    frame.motor   = frame_buf[IDX_MOTOR];
    // value sent most significant byte first
    frame.value   = {frame_buf[IDX_VAL_LO], frame_buf[IDX_VAL_LO + 4'h1],
                     frame_buf[IDX_VAL_LO + 4'h2], frame_buf[IDX_VAL_LO + 4'h3]};
    chk_ok        = (chk_final == frame_buf[FRAME_LAST]);
    fields_ok     = (frame.op_type == 8'h00) && (frame.motor == 8'h00) &&
                    (frame.instr != OP_SOFT_HALT || frame.value == 32'h0000_0000);
  end

  // sequencer: mode select always precedes parameter write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state             <= ST_IDLE;
      axis_write        <= '0;
      spin_dir_negative <= 1'b0;
      reply             <= '0;
      reply_valid       <= 1'b0;
      ext_op_valid      <= 1'b0;
      ext_op            <= 8'h00;
      ext_frame         <= '0;
    end else begin
      axis_write.valid <= 1'b0;
      ext_op_valid     <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (frame_done) begin
            reply.instr <= frame.instr;
            reply.value <= 32'h0000_0000; // value field is don't care
            if (!chk_ok) begin
              reply.status <= STATUS_BAD_CHKSUM;
              state        <= ST_REPLY;
            end else if (is_motion(frame.instr)) begin
              if (fields_ok) begin
                state <= ST_MODE;
              end else begin
                reply.status <= STATUS_BAD_TYPE;
                state        <= ST_REPLY;
              end
            end else if (is_extended(frame.instr) || frame.instr == OP_HANDLER_RET) begin
              // return opcode forwarded too, it ends the handler
              ext_op_valid <= 1'b1;
              ext_op       <= frame.instr;
              ext_frame    <= frame;
              reply.status <= STATUS_OK;
              state        <= ST_REPLY;
            end else begin
              reply.status <= STATUS_BAD_CMD;
              state        <= ST_REPLY;
            end
          end
        end
        ST_MODE: begin
          axis_write.valid         <= 1'b1;
          axis_write.velocity_mode <= 1'b1;
          axis_write.param         <= PARAM_TARGET_VELOCITY;
          axis_write.value         <= 32'h0000_0000;
          state                    <= ST_PARAM;
        end
        ST_PARAM: begin
          axis_write.valid <= 1'b1;
          if (frame.instr == OP_SOFT_HALT) begin
            axis_write.param <= PARAM_TARGET_SPEED;
            axis_write.value <= 32'h0000_0000;
          end else begin
            axis_write.param  <= PARAM_TARGET_VELOCITY;
            axis_write.value  <= frame.value;
            spin_dir_negative <= (frame.instr == OP_SPIN_NEG);
          end
          reply.status <= STATUS_OK;
          state        <= ST_REPLY;
        end
        ST_REPLY: begin
          reply_valid <= 1'b1;
          state       <= ST_WAIT;
        end
        ST_WAIT: begin
          if (reply_ready) begin
            reply_valid <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // single handler level: further requests ignored until return
  logic ret_seen;
  assign ret_seen = ext_op_valid && ext_op == OP_HANDLER_RET;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      handler_active  <= 1'b0;
      handler_enter   <= 1'b0;
      context_restore <= 1'b0;
      saved_context   <= '0;
    end else begin
      handler_enter   <= 1'b0;
      context_restore <= 1'b0;
      if (handler_active && ret_seen) begin
        handler_active  <= 1'b0;
        context_restore <= 1'b1;
      end else if (!handler_active && irq_request) begin
        handler_active <= 1'b1;
        handler_enter  <= 1'b1;
        saved_context  <= live_context;
      end
    end
  end

  AST_MODE_BEFORE_PARAM: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_MODE) |=> axis_write.valid && axis_write.velocity_mode ##1
      axis_write.valid && reply.status == STATUS_OK)
    else $error("mode select not followed by parameter write");
  AST_HALT_ZERO: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_PARAM && frame.instr == OP_SOFT_HALT) |=>
      axis_write.param == PARAM_TARGET_SPEED && axis_write.value == 32'h0000_0000)
    else $error("soft halt did not zero target speed");
  AST_SPIN_POS: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_PARAM && frame.instr == OP_SPIN_POS) |=>
      !spin_dir_negative && axis_write.param == PARAM_TARGET_VELOCITY)
    else $error("positive spin wrong");
  AST_SPIN_NEG: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_PARAM && frame.instr == OP_SPIN_NEG) |=> spin_dir_negative)
    else $error("negative spin wrong");
  AST_VELOCITY_VALUE: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_PARAM && frame.instr != OP_SOFT_HALT) |=>
      axis_write.value == $past(frame.value))
    else $error("velocity value not passed through");
  AST_REPLY_OK: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_PARAM) |-> ##2 reply_valid && reply.status == STATUS_OK)
    else $error("motion reply not ok");
  AST_EXT_DECODE: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_IDLE && frame_done && chk_ok && is_extended(frame.instr)) |=>
      ext_op_valid && ext_op == $past(frame.instr))
    else $error("extended opcode not issued");
  AST_NO_NEST: assert property (@(posedge mclk) disable iff (reset)
    handler_active && !ret_seen |=> handler_active && !handler_enter)
    else $error("handler nested");
  AST_RESTORE: assert property (@(posedge mclk) disable iff (reset)
    handler_active && ret_seen |=> context_restore && !handler_active)
    else $error("context not restored");
  AST_CHECKSUM: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_IDLE && frame_done && !chk_ok) |=> reply.status == STATUS_BAD_CHKSUM)
    else $error("bad checksum accepted");

  COV_SPIN: cover property (@(posedge mclk) disable iff (reset)
    state == ST_PARAM && frame.instr == OP_SPIN_POS);
  COV_HALT: cover property (@(posedge mclk) disable iff (reset)
    state == ST_PARAM && frame.instr == OP_SOFT_HALT);
  COV_EXT: cover property (@(posedge mclk) disable iff (reset) ext_op_valid);
  COV_HANDLER: cover property (@(posedge mclk) disable iff (reset)
    handler_enter ##[1:200] context_restore);

endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cmd_pkg::*;
  logic        mclk, reset, rx_valid, irq_request, reply_valid, reply_ready;
  logic        spin_dir_negative, ext_op_valid, handler_active;
  logic        handler_enter, context_restore;
  logic [7:0]  rx_byte, ext_op, last_ext;
  context_t    live_context, saved_context;
  axis_write_t axis_write;
  reply_t      reply;
  cmd_frame_t  ext_frame;
  axis_write_t wr [$];
  int          mismatches, checks_done, ext_n, enters, restores, cyc;

  stepper_command_interpreter dut (.mclk(mclk), .reset(reset), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .irq_request(irq_request), .live_context(live_context),
    .axis_write(axis_write), .spin_dir_negative(spin_dir_negative), .reply(reply),
    .reply_valid(reply_valid), .reply_ready(reply_ready), .ext_op_valid(ext_op_valid),
    .ext_op(ext_op), .ext_frame(ext_frame), .handler_active(handler_active),
    .handler_enter(handler_enter), .saved_context(saved_context),
    .context_restore(context_restore));
  host_model host (.mclk(mclk), .reply_valid(reply_valid), .reply(reply),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .reply_ready(reply_ready));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // pulses are collected half a cycle after the edge that made them
  always @(negedge mclk) begin
    if (axis_write.valid === 1'b1) wr.push_back(axis_write);
    if (ext_op_valid === 1'b1) begin
      ext_n++;
      last_ext = ext_op;
    end
    if (handler_enter === 1'b1) enters++;
    if (context_restore === 1'b1) restores++;
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [127:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic motion(input logic [7:0] ins, input logic [31:0] val,
                        input logic [7:0] par, input logic [31:0] pv, input int gap);
    reply_t r;
    wr.delete();
    host.send(ins, 8'h00, val, 1'b0, gap, r);
    chk(wr.size(), 2, "axis write count");
    chk({wr[0].velocity_mode, wr[1].param, wr[1].value}, {1'b1, par, pv}, "writes");
    chk({r.status, r.instr}, {STATUS_OK, ins}, "reply");
  endtask
  task automatic t_spin_pos;
    motion(OP_SPIN_POS, 32'h0000C800, PARAM_TARGET_VELOCITY, 32'h0000C800, 0);
    chk(spin_dir_negative, 1'b0, "direction");
    motion(OP_SPIN_POS, 32'h7FFFFFFF, PARAM_TARGET_VELOCITY, 32'h7FFFFFFF, 0);
    $display("spin positive done");
  endtask
  task automatic t_spin_neg;
    motion(OP_SPIN_NEG, 32'hFFFFD8F0, PARAM_TARGET_VELOCITY, 32'hFFFFD8F0, 2);
    chk(spin_dir_negative, 1'b1, "direction");
    motion(OP_SPIN_POS, 32'h00000100, PARAM_TARGET_VELOCITY, 32'h00000100, 0);
    chk(spin_dir_negative, 1'b0, "direction back");
    $display("spin negative done");
  endtask
  task automatic t_halt;
    motion(OP_SOFT_HALT, 32'h0, PARAM_TARGET_SPEED, 32'h0, 0);
    $display("soft halt done");
  endtask
  task automatic t_refuse;
    reply_t r;
    wr.delete();
    host.send(OP_SPIN_POS, 8'h00, 32'h10, 1'b1, 0, r);
    chk(r.status, STATUS_BAD_CHKSUM, "bad checksum");
    host.send(OP_SPIN_NEG, 8'h01, 32'h10, 1'b0, 0, r);
    chk(r.status, STATUS_BAD_TYPE, "motor one");
    host.send(OP_SOFT_HALT, 8'h00, 32'h5, 1'b0, 0, r);
    chk(r.status, STATUS_BAD_TYPE, "halt value");
    host.send(8'h2F, 8'h00, 32'h0, 1'b0, 0, r);
    chk(r.status, STATUS_BAD_CMD, "unknown op");
    chk(wr.size(), 0, "no axis write");
    $display("refusals done");
  endtask
  task automatic t_ext;
    logic [7:0] ops [15] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h30,
                             8'h31, 8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h50};
    reply_t     r;
    foreach (ops[i]) begin
      ext_n = 0;
      host.send(ops[i], 8'h00, 32'h01020304, 1'b0, 0, r);
      chk({ext_n, last_ext}, {32'd1, ops[i]}, "extended op");
      chk(ext_frame, {ops[i], 16'h0000, 32'h01020304}, "extended frame");
    end
    $display("extended ops done");
  endtask
  task automatic t_irq;
    context_t ctx;
    reply_t   r;
    ctx = {32'h12345678, 32'h9ABCDEF0, 4'hA};
    @(negedge mclk);
    live_context = ctx;
    irq_request = 1'b1;
    repeat (3) @(negedge mclk);
    chk({enters, handler_active, saved_context}, {32'd1, 1'b1, ctx}, "entry");
    live_context = ~ctx;
    repeat (6) @(negedge mclk);
    chk({enters, saved_context}, {32'd1, ctx}, "no nesting");
    irq_request = 1'b0;
    host.send(OP_HANDLER_RET, 8'h00, 32'h0, 1'b0, 0, r);
    chk({restores, handler_active}, {32'd1, 1'b0}, "return");
    $display("handler done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    irq_request = 1'b0;
    live_context = '0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    t_spin_pos;
    t_spin_neg;
    t_halt;
    t_refuse;
    t_ext;
    t_irq;
    report_and_stop;
  end
endmodule
`default_nettype wire
